/* File: hw/cdrb_top.sv */
// Diagnostic record builder for the counter technology function
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Byte 0: failure, external, channel error bits
// - Byte 1 low nibble: class 0101b or 1111b
// - Byte 1 bit 4 channel info, 7-5 zero
// - Incoming: byte 2 zero, byte 3 bit 6 lost
// - Outgoing only while enabled, bytes 2-3 zero
// - Same base record layout in every mode
// - Extended record: four base plus twelve bytes
// - Byte 4 channel type 70h, bit 7 more
// - Byte 5 diagnostic bits per channel 08h
// - Byte 6 number of channels 08h
// - Byte 7 group error flags, reserved zero
// - Byte 12 counter 0 lost event flags
// - Byte 13 counter 1 lost event flags
// - Repeat event while pending raises lost flag
// - Events in diagnostic window are discarded
module cdrb_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Avalon-MM slave
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Process interrupt events and error levels
  input wire logic [cdrb_pkg::CDRB_NUM_EVT-1:0] PI_EVT,
  input wire logic MOD_FAIL,
  input wire logic EXT_ERR,
  // Interrupt and diagnostic window
  output logic DIAG_IRQ,
  output logic DIAG_ACTIVE
);
  import cdrb_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Places four flags on the even bits of a byte
  function automatic logic [7:0] spread4(input logic [3:0] f);
    spread4 = {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic served;
  logic [2:0] ctrl;
  logic [2:0] irq_en;
  logic [2:0] irq_stat;
  logic [CDRB_NUM_EVT-1:0] pend;
  logic [CDRB_NUM_EVT-1:0] lost;
  logic [4:0] grp_q;
  logic outgoing;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait cycle per access keeps read data on a flip-flop
  wire logic wr_fire = AVS_WRITE && served;
  wire logic hit_ctrl = AVS_ADDRESS == CDRB_OFS_CTRL;
  wire logic hit_ack = AVS_ADDRESS == CDRB_OFS_PI_ACK;
  wire logic hit_lclr = AVS_ADDRESS == CDRB_OFS_LOST_CLR;
  wire logic hit_iclr = AVS_ADDRESS == CDRB_OFS_IRQ_CLR;
  wire logic hit_ien = AVS_ADDRESS == CDRB_OFS_IRQ_EN;
  wire logic [CDRB_NUM_EVT-1:0] ack_wr =
    (wr_fire && hit_ack) ? AVS_WRITEDATA[CDRB_NUM_EVT-1:0] : '0;
  wire logic [CDRB_NUM_EVT-1:0] lclr_wr =
    (wr_fire && hit_lclr) ? AVS_WRITEDATA[CDRB_NUM_EVT-1:0] : '0;
  wire logic [2:0] iclr_wr = (wr_fire && hit_iclr) ? AVS_WRITEDATA[2:0] : 3'h0;
  wire logic diag_en = ctrl[CDRB_CTRL_DIAG_EN];

  // ----------------------------------------------------------------
  // Channel groups and diagnostic window
  // ----------------------------------------------------------------
  // Groups: inputs 0.0-0.3, 0.4-0.7, 1.0-1.1, counter 0, counter 1
  wire logic [4:0] grp_lost = {|lost[17:14], |lost[13:10], |lost[9:8],
                               |lost[7:4], |lost[3:0]};
  // A group stays in its window from the first lost flag until cleared
  wire logic [CDRB_NUM_EVT-1:0] win_evt = {{4{grp_lost[4]}}, {4{grp_lost[3]}},
                                           {2{grp_lost[2]}}, {4{grp_lost[1]}},
                                           {4{grp_lost[0]}}};
  wire logic any_lost = |lost;
  wire logic [CDRB_NUM_EVT-1:0] evt_ok = PI_EVT & ~win_evt;
  wire logic [CDRB_NUM_EVT-1:0] lost_set = evt_ok & pend;
  wire logic [CDRB_NUM_EVT-1:0] pend_set = evt_ok & ~pend;
  // Incoming on a new lost flag, outgoing when a group window closes in a cycle without a new lost flag
  wire logic in_evt = diag_en && (|(lost_set & ~lost));
  wire logic out_evt = diag_en && (|(grp_q & ~grp_lost)) && !in_evt;
  wire logic pi_evt = |pend_set;

  // ----------------------------------------------------------------
  // Record bytes
  // ----------------------------------------------------------------
  // One base layout serves counting, frequency and pulse modes
  wire logic [7:0] rec_b0 = {4'h0, any_lost, EXT_ERR, 1'b0, MOD_FAIL};
  wire logic [3:0] class_code =
    ctrl[CDRB_CTRL_ANALOG] ? CDRB_CLASS_ANALOG : CDRB_CLASS_DIGITAL;
  wire logic [7:0] rec_b1 = {3'h0, any_lost, class_code};
  wire logic [7:0] rec_b2 = CDRB_FIXED_ZERO;
  wire logic [7:0] rec_b3 = outgoing ? CDRB_FIXED_ZERO : {1'b0, any_lost, 6'h00};
  wire logic [7:0] rec_b4 = {ctrl[CDRB_CTRL_MORE_TYPES], CDRB_CHTYPE_DIG_IN};
  wire logic [7:0] rec_b5 = CDRB_DIAG_BITS_PER_CH;
  wire logic [7:0] rec_b6 = CDRB_NUM_CHANNELS;
  wire logic [7:0] rec_b7 = {2'h0, grp_lost[4:3], 1'b0, grp_lost[2:0]};
  wire logic [7:0] rec_b8 = spread4(lost[3:0]);
  wire logic [7:0] rec_b9 = spread4(lost[7:4]);
  wire logic [7:0] rec_b10 = spread4({2'h0, lost[9:8]});
  wire logic [7:0] rec_b11 = CDRB_FIXED_ZERO;
  wire logic [7:0] rec_b12 = spread4(lost[13:10]);
  wire logic [7:0] rec_b13 = spread4(lost[17:14]);
  wire logic [7:0] rec_b14 = CDRB_FIXED_ZERO;
  wire logic [7:0] rec_b15 = CDRB_FIXED_ZERO;
  // Sixteen bytes, base record first, little endian words
  wire logic [31:0] rec_w0 = {rec_b3, rec_b2, rec_b1, rec_b0};
  wire logic [31:0] rec_w1 = {rec_b7, rec_b6, rec_b5, rec_b4};
  wire logic [31:0] rec_w2 = {rec_b11, rec_b10, rec_b9, rec_b8};
  wire logic [31:0] rec_w3 = {rec_b15, rec_b14, rec_b13, rec_b12};

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Write-only and unmapped words read zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (AVS_ADDRESS)
      CDRB_OFS_CTRL: rd_mux = {29'h0, ctrl};
      CDRB_OFS_PI_PEND: rd_mux = {14'h0, pend};
      CDRB_OFS_REC_W0: rd_mux = rec_w0;
      CDRB_OFS_REC_W1: rd_mux = rec_w1;
      CDRB_OFS_REC_W2: rd_mux = rec_w2;
      CDRB_OFS_REC_W3: rd_mux = rec_w3;
      CDRB_OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat};
      CDRB_OFS_IRQ_EN: rd_mux = {29'h0, irq_en};
      default: rd_mux = 32'h0;
    endcase
  end

  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !served;
  assign DIAG_IRQ = |(irq_stat & irq_en);
  assign DIAG_ACTIVE = any_lost;

  // ----------------------------------------------------------------
  // Bus handshake and read data
  // ----------------------------------------------------------------
  // Read data is caught in the wait cycle and stands at completion
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      served <= 1'b0;
      AVS_READDATA <= 32'h0;
    end else begin
      served <= (AVS_READ || AVS_WRITE) && !served;
      if (AVS_READ && !served) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and interrupt registers
  // ----------------------------------------------------------------
  // Status set wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      ctrl <= CDRB_CTRL_RST;
      irq_en <= CDRB_IRQ_EN_RST;
      irq_stat <= 3'h0;
    end else begin
      if (wr_fire && hit_ctrl) begin
        ctrl <= AVS_WRITEDATA[2:0];
      end
      if (wr_fire && hit_ien) begin
        irq_en <= AVS_WRITEDATA[2:0];
      end
      irq_stat <= (irq_stat & ~iclr_wr) | {pi_evt, out_evt, in_evt};
    end
  end

  // ----------------------------------------------------------------
  // Record kind and group history
  // ----------------------------------------------------------------
  // Outgoing is only emitted with the enable still on
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      outgoing <= 1'b0;
      grp_q <= 5'h0;
    end else begin
      grp_q <= grp_lost;
      if (in_evt) begin
        outgoing <= 1'b0;
      end else if (out_evt) begin
        outgoing <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-event pending and lost flags
  // ----------------------------------------------------------------
  // Pending tracks a process interrupt still being handled
  genvar gi;
  generate
    for (gi = 0; gi < CDRB_NUM_EVT; gi++) begin : g_evt
      always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
          pend[gi] <= 1'b0;
          lost[gi] <= 1'b0;
        end else begin
          // A new event beats a software acknowledge
          pend[gi] <= evt_ok[gi] | (pend[gi] & ~ack_wr[gi]);
          lost[gi] <= lost_set[gi] | (lost[gi] & ~lclr_wr[gi]);
        end
      end

      // Repeat event while pending must latch its lost flag
      chk_lost_latch: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        PI_EVT[gi] && pend[gi] && !win_evt[gi] |=> lost[gi] && pend[gi])
        else $error("repeat event did not set lost flag");
      // Event inside an open window must not become pending
      chk_window_drop: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        PI_EVT[gi] && win_evt[gi] && !pend[gi] |=> !pend[gi])
        else $error("event in diagnostic window was stored");
      // A discarded event must leave no lost flag behind
      chk_window_no_lost: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        PI_EVT[gi] && win_evt[gi] && !lost[gi] |=> !lost[gi])
        else $error("event in diagnostic window set a lost flag");
      // Accepted event stays pending, even against an acknowledge
      chk_pend_wins: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        PI_EVT[gi] && !win_evt[gi] |=> pend[gi])
        else $error("accepted event is not pending");
      // Acknowledge without a new event ends pending
      chk_pend_ack: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        pend[gi] && ack_wr[gi] && !PI_EVT[gi] |=> !pend[gi])
        else $error("pending flag survived its acknowledge");
      // Lost flag holds until software clears it
      chk_lost_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        lost[gi] && !lclr_wr[gi] |=> lost[gi])
        else $error("lost flag dropped without a clear");
      // Only a repeat of a pending event may mark it lost
      chk_lost_needs_pend: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        !pend[gi] && !lost[gi] |=> !lost[gi])
        else $error("lost flag set with nothing pending");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  chk_b0_fields: assert property (
    $rose(any_lost) |-> rec_b0[3] && rec_b0[1] == 1'b0 && rec_b0[7:4] == 4'h0)
    else $error("byte 0 channel error or fixed bits wrong");
  chk_class_code: assert property (
    ##1 $past(ctrl[CDRB_CTRL_ANALOG]) |-> ($stable(ctrl) -> rec_b1[3:0] == 4'h5))
    else $error("analog class code wrong");
  chk_b1_info: assert property (
    rec_b1[4] == (rec_b7 != 8'h00) && rec_b1[7:5] == 3'h0)
    else $error("channel info bit disagrees with group errors");
  chk_incoming_b3: assert property (
    in_evt |=> rec_b3 == 8'h40 && rec_b2 == 8'h00)
    else $error("incoming record bytes 2 or 3 wrong");
  chk_outgoing_gate: assert property (
    (|(grp_q & ~grp_lost)) && !diag_en |=> $stable(irq_stat[CDRB_IRQ_OUTGOING]) ||
      !irq_stat[CDRB_IRQ_OUTGOING])
    else $error("outgoing raised with enable off");
  chk_outgoing_zero: assert property (
    out_evt |=> rec_w0[31:16] == 16'h0 && irq_stat[CDRB_IRQ_OUTGOING])
    else $error("outgoing record bytes 2 and 3 not zero");
  chk_ext_consts: assert property (
    rec_w1[23:0] == {8'h08, 8'h08, ctrl[CDRB_CTRL_MORE_TYPES], 7'h70})
    else $error("extended record constants wrong");
  chk_grp_reserved: assert property (
    (rec_b7 & 8'hc8) == 8'h00 && rec_b7[4] == (rec_b12 != 8'h00))
    else $error("group error byte wrong");
  chk_odd_zero: assert property (
    ((rec_b8 | rec_b9 | rec_b10 | rec_b12 | rec_b13) & 8'haa) == 8'h00 &&
      rec_b10[7:4] == 4'h0)
    else $error("odd lost bits not zero");
  chk_cnt_flags: assert property (
    lost_set[12] && !lost[12] |=> rec_b12[4] && rec_b7[4] ##1 rec_b12[4] || $past(lclr_wr[12]))
    else $error("counter 0 limit lost flag missing");
  chk_cnt1_flags: assert property (
    lost_set[17] |=> rec_b13[6] && rec_b7[5])
    else $error("counter 1 compare lost flag missing");
  chk_reserved_zero: assert property (
    rec_b11 == 8'h00 && rec_b14 == 8'h00 && rec_b15 == 8'h00)
    else $error("reserved record bytes not zero");
  chk_bus_answer: assert property (
    (AVS_READ || AVS_WRITE) && !served |=> !AVS_WAITREQUEST)
    else $error("bus answer later than one wait cycle");

  // ----------------------------------------------------------------
  // Status and control checks
  // ----------------------------------------------------------------
  // Status bits are sticky; only a clear or a new event changes them
  chk_incoming_flag: assert property (
    diag_en && (|(lost_set & ~lost)) |=> irq_stat[CDRB_IRQ_INCOMING])
    else $error("incoming status not set on a new lost flag");
  chk_process_flag: assert property (
    (|pend_set) |=> irq_stat[CDRB_IRQ_PROCESS])
    else $error("process status not set on a new event");
  chk_status_sticky: assert property (
    irq_stat[CDRB_IRQ_PROCESS] && !iclr_wr[CDRB_IRQ_PROCESS] |=> irq_stat[CDRB_IRQ_PROCESS])
    else $error("process status dropped without a clear");
  chk_outgoing_clear: assert property (
    iclr_wr[CDRB_IRQ_OUTGOING] && !out_evt |=> !irq_stat[CDRB_IRQ_OUTGOING])
    else $error("outgoing status survived its clear");
  // An incoming record always shows its lost bit, never the outgoing form
  chk_outgoing_kind: assert property (
    in_evt |=> !outgoing)
    else $error("incoming left the outgoing form selected");
  // Register writes land at the completing edge
  chk_ctrl_write: assert property (
    wr_fire && hit_ctrl |=> ctrl == $past(AVS_WRITEDATA[2:0]))
    else $error("control write did not land");
  chk_irq_en_write: assert property (
    wr_fire && hit_ien |=> irq_en == $past(AVS_WRITEDATA[2:0]))
    else $error("interrupt enable write did not land");
  // Read data must not move between reads, so a slow master still sees it
  chk_readdata_hold: assert property (
    !(AVS_READ && !served) |=> $stable(AVS_READDATA))
    else $error("read data moved outside a read");
  chk_idle_wait: assert property (
    !AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("waitrequest raised with no request");
  chk_class_digital: assert property (
    !ctrl[CDRB_CTRL_ANALOG] |-> rec_b1[3:0] == 4'hf)
    else $error("digital class code wrong");

  cov_incoming: cover property (in_evt ##[1:50] out_evt);
  cov_outgoing_open: cover property (out_evt && any_lost);
  cov_discard: cover property (|(PI_EVT & win_evt));
  cov_irq: cover property ($rose(DIAG_IRQ));
  cov_set_clear: cover property (|(lost_set & lclr_wr));

endmodule // cdrb_top

`default_nettype wire

/* File: shared/cdrb_pkg.sv */
// Constants for the counter diagnostic record builder
package cdrb_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the Avalon-MM slave
  // ----------------------------------------------------------------
  localparam logic [5:0] CDRB_OFS_CTRL = 6'h00;
  localparam logic [5:0] CDRB_OFS_PI_ACK = 6'h04;
  localparam logic [5:0] CDRB_OFS_PI_PEND = 6'h08;
  localparam logic [5:0] CDRB_OFS_LOST_CLR = 6'h0c;
  localparam logic [5:0] CDRB_OFS_REC_W0 = 6'h10;
  localparam logic [5:0] CDRB_OFS_REC_W1 = 6'h14;
  localparam logic [5:0] CDRB_OFS_REC_W2 = 6'h18;
  localparam logic [5:0] CDRB_OFS_REC_W3 = 6'h1c;
  localparam logic [5:0] CDRB_OFS_IRQ_STAT = 6'h20;
  localparam logic [5:0] CDRB_OFS_IRQ_CLR = 6'h24;
  localparam logic [5:0] CDRB_OFS_IRQ_EN = 6'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CDRB_CTRL_DIAG_EN = 0;
  localparam int CDRB_CTRL_ANALOG = 1;
  localparam int CDRB_CTRL_MORE_TYPES = 2;
  localparam int CDRB_IRQ_INCOMING = 0;
  localparam int CDRB_IRQ_OUTGOING = 1;
  localparam int CDRB_IRQ_PROCESS = 2;
  localparam int CDRB_B3_LOST = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CDRB_CTRL_RST = 3'h0;
  localparam logic [2:0] CDRB_IRQ_EN_RST = 3'h0;

  // ----------------------------------------------------------------
  // Record codes and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CDRB_CLASS_ANALOG = 4'h5;
  localparam logic [3:0] CDRB_CLASS_DIGITAL = 4'hf;
  localparam logic [6:0] CDRB_CHTYPE_DIG_IN = 7'h70;
  localparam logic [7:0] CDRB_DIAG_BITS_PER_CH = 8'h08;
  localparam logic [7:0] CDRB_NUM_CHANNELS = 8'h08;
  localparam logic [7:0] CDRB_FIXED_ZERO = 8'h00;
  localparam int CDRB_NUM_EVT = 18;
  localparam int CDRB_NUM_INPUTS = 10;

endpackage

/* File: verification/cdrb_top_tb_top.sv */
// Self-checking testbench for the counter diagnostic record builder
`timescale 1ns/100ps
`default_nettype none

module cdrb_top_tb_top;
  import cdrb_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic CLK_SYS;
  logic RST_B;
  logic [5:0] AVS_ADDRESS;
  logic AVS_READ;
  logic AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [CDRB_NUM_EVT-1:0] PI_EVT;
  logic MOD_FAIL;
  logic EXT_ERR;
  logic DIAG_IRQ;
  logic DIAG_ACTIVE;
  int mismatches;
  int num_checks;
  int g;
  int p;
  int f;
  int sib;
  logic [31:0] q;

  cdrb_top u_cdrb_top (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .PI_EVT(PI_EVT), .MOD_FAIL(MOD_FAIL),
    .EXT_ERR(EXT_ERR), .DIAG_IRQ(DIAG_IRQ), .DIAG_ACTIVE(DIAG_ACTIVE)
  );

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Single verdict point, also reached by an expired wait
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Request held from one edge on; waitrequest, read data and the write all
  // belong to the rising edge that ends the transfer, release follows it
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= ~wr;
    AVS_WRITE <= wr;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (AVS_WAITREQUEST !== 1'b0) begin
      mismatches++;
      $display("[FAIL] %0t bus wait expired", $time);
      wrap_up();
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, exp, msg);
  endtask

  // Pins are compared mid-cycle where they are settled
  task automatic pin_chk(input logic irq, input logic act);
    @(negedge CLK_SYS);
    chk({30'h0, DIAG_IRQ, DIAG_ACTIVE}, {30'h0, irq, act}, "irq or window pin");
  endtask

  // One-cycle event pulse
  task automatic pulse(input int i);
    @(posedge CLK_SYS);
    PI_EVT <= 18'h1 << i;
    @(posedge CLK_SYS);
    PI_EVT <= '0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    num_checks = 0;
    RST_B = 1'b0;
    AVS_ADDRESS = '0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = '0;
    PI_EVT = '0;
    MOD_FAIL = 1'b0;
    EXT_ERR = 1'b0;
    repeat (12) @(posedge CLK_SYS);
    RST_B <= 1'b1;

    // Reset values, record defaults, write-only and unmapped places
    rd_chk(CDRB_OFS_CTRL, 32'h0, "ctrl reset");
    rd_chk(CDRB_OFS_IRQ_EN, 32'h0, "irq enable reset");
    rd_chk(CDRB_OFS_IRQ_STAT, 32'h0, "irq status reset");
    rd_chk(CDRB_OFS_REC_W0, 32'h00000f00, "base record idle");
    rd_chk(CDRB_OFS_REC_W1, 32'h00080870, "type and counts");
    rd_chk(CDRB_OFS_REC_W2, 32'h0, "input lost bytes idle");
    rd_chk(CDRB_OFS_REC_W3, 32'h0, "counter lost bytes idle");
    rd_chk(CDRB_OFS_PI_ACK, 32'h0, "write-only reads zero");
    wr(6'h3c, 32'hffffffff);
    rd_chk(6'h3c, 32'h0, "unmapped reads zero");
    $display("test reset done");

    // Error levels, analog class and more channel types
    MOD_FAIL <= 1'b1;
    EXT_ERR <= 1'b1;
    wr(CDRB_OFS_CTRL, 32'h6);
    rd_chk(CDRB_OFS_REC_W0, 32'h00000505, "fail, ext error, analog class");
    rd_chk(CDRB_OFS_REC_W1, 32'h000808f0, "more channel types flag");
    MOD_FAIL <= 1'b0;
    EXT_ERR <= 1'b0;
    wr(CDRB_OFS_CTRL, 32'h1);
    wr(CDRB_OFS_IRQ_EN, 32'h7);
    $display("test levels done");

    // Every event: pending, lost, group discard, outgoing
    for (int i = 0; i < CDRB_NUM_EVT; i++) begin
      g = (i < 10) ? i / 4 : 4 + (i - 10) / 4;
      p = (i < 10) ? i : i - 10;
      f = (i < 10) ? 4 * (i / 4) : 10 + 4 * ((i - 10) / 4);
      sib = (i == f) ? i + 1 : f;
      wr(CDRB_OFS_IRQ_CLR, 32'h7);
      pulse(i);
      rd_chk(CDRB_OFS_PI_PEND, 32'h1 << i, "pending flag");
      rd_chk(CDRB_OFS_IRQ_STAT, 32'h4, "process event only");
      pulse(i);
      rd_chk(CDRB_OFS_IRQ_STAT, 32'h5, "incoming raised");
      rd_chk(CDRB_OFS_REC_W0, 32'h40001f08, "incoming base record");
      rd_chk(CDRB_OFS_REC_W1, 32'h00080870 | (32'h1 << (24 + g)), "group error");
      rd_chk(CDRB_OFS_REC_W2, (i < 10) ? 32'h1 << (8 * (p / 4) + 2 * (p % 4)) : 32'h0,
             "input lost bits");
      rd_chk(CDRB_OFS_REC_W3, (i >= 10) ? 32'h1 << (8 * (p / 4) + 2 * (p % 4)) : 32'h0,
             "counter lost bits");
      pin_chk(1'b1, 1'b1);
      pulse(sib);
      rd_chk(CDRB_OFS_PI_PEND, 32'h1 << i, "event in window discarded");
      wr(CDRB_OFS_PI_ACK, 32'h3ffff);
      wr(CDRB_OFS_IRQ_CLR, 32'h7);
      wr(CDRB_OFS_LOST_CLR, 32'h3ffff);
      rd_chk(CDRB_OFS_IRQ_STAT, 32'h2, "outgoing raised");
      rd_chk(CDRB_OFS_REC_W0, 32'h00000f00, "outgoing base record");
      pin_chk(1'b1, 1'b0);
      wr(CDRB_OFS_IRQ_CLR, 32'h7);
      pin_chk(1'b0, 1'b0);
    end
    $display("test events done");

    // Outgoing while another group's window stays open
    pulse(0);
    pulse(0);
    pulse(10);
    pulse(10);
    wr(CDRB_OFS_LOST_CLR, 32'h1);
    rd_chk(CDRB_OFS_IRQ_STAT, 32'h7, "incoming, outgoing and process");
    rd_chk(CDRB_OFS_REC_W0, 32'h00001f08, "outgoing record, window open");
    rd_chk(CDRB_OFS_REC_W1, 32'h10080870, "counter group still open");
    pin_chk(1'b1, 1'b1);
    wr(CDRB_OFS_PI_ACK, 32'h3ffff);
    wr(CDRB_OFS_LOST_CLR, 32'h3ffff);
    wr(CDRB_OFS_IRQ_CLR, 32'h7);
    $display("test open windows done");

    // Diagnostics disabled: no incoming, no outgoing; masking
    wr(CDRB_OFS_CTRL, 32'h0);
    wr(CDRB_OFS_IRQ_EN, 32'h0);
    pulse(0);
    pulse(0);
    rd_chk(CDRB_OFS_IRQ_STAT, 32'h4, "no incoming when disabled");
    rd_chk(CDRB_OFS_REC_W2, 32'h1, "lost flag kept when disabled");
    pin_chk(1'b0, 1'b1);
    wr(CDRB_OFS_LOST_CLR, 32'h1);
    rd_chk(CDRB_OFS_IRQ_STAT, 32'h4, "no outgoing when disabled");
    wr(CDRB_OFS_IRQ_EN, 32'h4);
    pin_chk(1'b1, 1'b0);
    wr(CDRB_OFS_IRQ_CLR, 32'h4);
    rd_chk(CDRB_OFS_IRQ_STAT, 32'h0, "status cleared");
    pin_chk(1'b0, 1'b0);
    $display("test disabled done");
    wrap_up();
  end

  // Guard against a hang outside the bus waits
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    mismatches++;
    $display("[FAIL] %0t run limit expired", $time);
    wrap_up();
  end
endmodule // cdrb_top_tb_top

`default_nettype wire
